// ### srctl_filter.sv
`timescale 1ns/1ps
// Persistence filter: output follows input only after it held for len cycles
module srctl_filter
	import srctl_pkg::*;
(
	input  wire logic             pclk,    // clock
	input  wire logic             presetn, // async reset, low
	input  wire logic             init,    // idle level, unused; reset value is 0
	input  wire logic             din,     // synchronous input
	input  wire logic [CNT_W-1:0] len,     // required hold, cycles
	output logic                  dout     // filtered level
);
	logic [CNT_W-1:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt  <= '0;
			dout <= 1'b0;
		end else if (din == dout) begin
			cnt <= '0;
		end else if (cnt + 16'h0001 >= len) begin
			cnt  <= '0;
			dout <= din;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end

	// Init only documents the idle level; reset value is a constant
	logic unused_init;
	assign unused_init = init;
endmodule : srctl_filter

// ### srctl_partner.sv
`timescale 1ns/1ps
module srctl_partner
	import srctl_pkg::*;
(
	input  wire logic           pclk,                     // clock
	input  wire logic           presetn,                  // reset, low
	input  wire srctl_rst_out_t rst_out,                  // controller resets
	input  wire logic [2:0]     fire,                     // {sysreq, lockup, wdt} pulses
	input  wire logic           cancel,                   // withdraw requests
	input  wire logic [3:0]     lvl,                      // {pin low, debug, bod, lvr}
	output srctl_hw_src_t       hw_src,                   // hardware sources
	output logic                external_reset_pin_n,     // reset pin
	output logic                system_reset_request_bit  // core request
);
	logic [2:0] held;

	// Watchdog, lockup and request pulses stay asserted until cancel or a core reset clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held <= 3'h0;
		end else if (cancel || rst_out.core_rst) begin
			held <= 3'h0;
		end else begin
			held <= held | fire;
		end
	end

	assign hw_src = '{wdt_timeout: held[0], lowvolt: lvl[0], brownout: lvl[1],
		core_lockup: held[1], debug_mode: lvl[2]};
	assign external_reset_pin_n = !lvl[3];
	assign system_reset_request_bit = held[2];
endmodule : srctl_partner

// ### srctl_pkg.sv
package srctl_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CAUSE    = 12'h000; // reset_cause_status
	localparam logic [11:0] ADDR_SWRST    = 12'h004; // software_reset_control
	localparam logic [11:0] ADDR_VDCTL    = 12'h008; // voltage_detect_control
	localparam logic [11:0] ADDR_WDCTL    = 12'h00C; // watchdog_control
	localparam logic [11:0] ADDR_OSCSTB   = 12'h010; // oscillator stable flags
	localparam logic [11:0] ADDR_BOOT     = 12'h014; // boot_select

	// ------------------------------------------------------------
	// Cause flag positions
	// ------------------------------------------------------------
	localparam int CAUSE_POR   = 0;
	localparam int CAUSE_PIN   = 1;
	localparam int CAUSE_WDT   = 2;
	localparam int CAUSE_LVR   = 3;
	localparam int CAUSE_BOD   = 4;
	localparam int CAUSE_MCU   = 5;
	localparam int CAUSE_CORE  = 7;
	localparam int CAUSE_LOCK  = 8;
	localparam int CAUSE_W     = 9;

	// Software reset control bits
	localparam int SW_CHIP     = 0;
	localparam int SW_CORE     = 1;

	// Voltage detect control fields
	localparam int VD_BROWNOUT_ENABLE    = 0;
	localparam int VD_BROWNOUT_LEVEL_LO = 1;
	localparam int VD_BODRST   = 3;
	localparam int VD_LOWVOLT_RESET_ENABLE    = 7;
	localparam int VD_BODDG_LO = 8;
	localparam int VD_LVRDG_LO = 12;

	// User configuration word fields
	localparam int CFG_BOOT    = 1;
	localparam int CFG_BODRST  = 20;
	localparam int CFG_BROWNOUT_LEVEL_LO = 21;
	localparam int CFG_BROWNOUT_ENABLE   = 23;
	localparam int CFG_WDT_RST = 1;
	localparam int CFG_WDT_EN  = 7;

	// Reset values
	localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL  = 9'h001;
	localparam logic [15:0]        WDCTL_RST_VAL  = 16'h0700;
	localparam logic [3:0]         OSCSTB_RST_VAL = 4'h0;
	localparam logic [2:0]         DG_OFF         = 3'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int PIN_FILTER_US  = 32;
	localparam int LVR_SETTLE_US  = 200;
	// Strictly longer than the time: one extra cycle
	localparam int PIN_FILTER_CYC = PIN_FILTER_US * CLK_MHZ + 1;
	localparam int LVR_SETTLE_CYC = LVR_SETTLE_US * CLK_MHZ;
	localparam int DG_UNIT_CYC    = 16;
	localparam int CNT_W          = 16;

	// Hardware reset sources
	typedef struct packed {
		logic wdt_timeout;   // watchdog or window watchdog
		logic lowvolt;       // low-voltage comparator, high = low supply
		logic brownout;      // brown-out comparator, high = low supply
		logic core_lockup;   // core locked up
		logic debug_mode;    // debugger attached
	} srctl_hw_src_t;

	// Reset outputs
	typedef struct packed {
		logic core_rst;      // processor core reset
		logic periph_rst;    // peripheral reset
		logic boot_reload;   // reload boot select from configuration
	} srctl_rst_out_t;

	// De-glitch length: select 0 is off, else 16 << sel cycles
	function automatic logic [CNT_W-1:0] srctl_dg_cycles(input logic [2:0] sel);
		srctl_dg_cycles = (sel == DG_OFF) ? 16'h0001 : CNT_W'(DG_UNIT_CYC << sel);
	endfunction : srctl_dg_cycles

endpackage : srctl_pkg

// ### srctl_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Nine sources; core-only reset spares peripherals
// (RULE2) Cause flags at fixed status bit positions
// (RULE3) Power-on sets status 0x001; write-one clears
// (RULE4) Pin low over 32us resets, high releases
// (RULE5) Pin reset sets status bit 1
// (RULE6) Low-voltage reset waits 200us after enable
// (RULE7) Low-voltage de-glitch from control bits 14:12
// (RULE8) Low-voltage on, no de-glitch; sets bit 3
// (RULE9) Brown-out de-glitch from control bits 10:8
// (RULE10) Brown-out settings load from config bits 23..20
// (RULE11) Watchdog reset sets status bit 2
// (RULE12) Lockup causes reset, sets status bit 8
// (RULE13) Lockup ignored while in debug mode
// (RULE14) Core reset bit resets core, sets bit 7
// (RULE15) Chip reset bit acts as power-on reset
// (RULE16) System request resets, keeps boot select, bit 5
// (RULE17) Watchdog control to 0x0700 on listed resets
// (RULE18) Uncovered state kept; oscillator flags power-on only
// (RULE19) Hardware via reset signals, software via registers
// (RULE20) Reset pin is asynchronous, synchronised first
// (RULE21) Flags clear only on software write-one
module srctl_top
	import srctl_pkg::*;
(
	input  wire logic           pclk,                    // APB clock, 100 MHz
	input  wire logic           presetn,                 // power-on reset, low
	input  wire logic           psel,                    // APB select
	input  wire logic           penable,                 // APB enable
	input  wire logic           pwrite,                  // APB direction
	input  wire logic [11:0]    paddr,                   // APB byte address
	input  wire logic [31:0]    pwdata,                  // APB write data
	output logic      [31:0]    prdata,                  // APB read data
	output logic                pready,                  // APB ready
	output logic                pslverr,                 // APB error
	input  wire logic           external_reset_pin_n,    // reset pin, low active
	input  wire logic [31:0]    user_config_word,        // configuration word
	input  wire logic           system_reset_request_bit, // core reset request
	input  wire srctl_hw_src_t  hw_src,                  // hardware sources
	input  wire logic [3:0]     osc_stable_set,          // oscillators stable
	output srctl_rst_out_t      rst_out,                 // reset outputs
	output logic [15:0]         watchdog_control,        // watchdog control
	output logic [7:0]          voltage_detect_control_q, // detector settings
	output logic                boot_select              // boot select
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [5:0] async_in;

	assign async_in = {external_reset_pin_n, hw_src.wdt_timeout, hw_src.lowvolt,
		hw_src.brownout, hw_src.core_lockup, hw_src.debug_mode};

	always_ff @(posedge pclk or negedge presetn) begin // [RULE20]
		if (!presetn) begin
			sync1 <= 6'h20;
			sync2 <= 6'h20;
		end else begin
			sync1 <= async_in;
			sync2 <= sync1;
		end
	end

	logic pin_low_s, wdt_s, lv_s, bod_s, lock_s, dbg_s;
	assign pin_low_s = ~sync2[5];
	assign wdt_s     = sync2[4];
	assign lv_s      = sync2[3];
	assign bod_s     = sync2[2];
	assign lock_s    = sync2[1];
	assign dbg_s     = sync2[0];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [CAUSE_W-1:0] reset_cause_status;
	logic [1:0]         software_reset_control;
	logic [2:0]         lowvolt_deglitch_select;
	logic [2:0]         brownout_deglitch_select;
	logic               lowvolt_reset_enable;
	logic               brownout_enable;
	logic [1:0]         brownout_level;
	logic               brownout_reset_enable;
	logic [3:0]         osc_stable;
	logic               cfg_loaded;

	// ------------------------------------------------------------
	// Filters
	// ------------------------------------------------------------
	logic pin_rst, lv_filt, bod_filt;

	srctl_filter u_pin_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.init    (1'b0),
		.din     (pin_low_s),
		.len     (CNT_W'(PIN_FILTER_CYC)),
		.dout    (pin_rst)                                // [RULE4]
	);

	srctl_filter u_lv_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.init    (1'b0),
		.din     (lv_s),
		.len     (srctl_dg_cycles(lowvolt_deglitch_select)),
		.dout    (lv_filt)                                // [RULE7]
	);

	srctl_filter u_bod_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.init    (1'b0),
		.din     (bod_s & brownout_enable),
		.len     (srctl_dg_cycles(brownout_deglitch_select)),
		.dout    (bod_filt)                               // [RULE9]
	);

	// ------------------------------------------------------------
	// Low-voltage settle timer
	// ------------------------------------------------------------
	logic [CNT_W-1:0] lv_settle_cnt;
	logic             lv_active;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv_settle_cnt <= '0;
			lv_active     <= 1'b0;
		end else if (!lowvolt_reset_enable) begin
			lv_settle_cnt <= '0;
			lv_active     <= 1'b0;
		end else if (!lv_active) begin
			if (lv_settle_cnt + 16'h0001 >= CNT_W'(LVR_SETTLE_CYC)) begin
				lv_active <= 1'b1;                                // [RULE6]
			end
			lv_settle_cnt <= lv_settle_cnt + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Source qualification
	// ------------------------------------------------------------
	logic lv_rst, bod_rst, lock_rst;
	logic chip_req, core_req, mcu_req;
	logic apb_wr;

	assign apb_wr   = psel & penable & pwrite;
	assign lv_rst   = lv_filt & lv_active;
	assign bod_rst  = bod_filt & brownout_reset_enable;
	assign lock_rst = lock_s & ~dbg_s;                             // [RULE13] [RULE12]
	assign chip_req = apb_wr & (paddr == ADDR_SWRST) & pwdata[SW_CHIP]; // [RULE19]
	assign core_req = apb_wr & (paddr == ADDR_SWRST) & pwdata[SW_CORE];
	assign mcu_req  = system_reset_request_bit;

	// Full-chip group restores watchdog control and, except on brown-out, the brown-out settings
	logic full_grp, sys_grp;
	assign full_grp = pin_rst | wdt_s | lv_rst | bod_rst | chip_req;     // [RULE17]
	assign sys_grp  = full_grp | lock_rst | mcu_req;                    // [RULE1]

	// ------------------------------------------------------------
	// Reset outputs
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_out <= '{core_rst: 1'b1, periph_rst: 1'b1, boot_reload: 1'b1};
		end else begin
			rst_out.core_rst    <= sys_grp | core_req;                 // [RULE14]
			rst_out.periph_rst  <= sys_grp;                            // [RULE1]
			rst_out.boot_reload <= full_grp & ~mcu_req;                // [RULE15] [RULE16]
		end
	end

	// ------------------------------------------------------------
	// Cause flags: set wins over clear
	// ------------------------------------------------------------
	logic [CAUSE_W-1:0] cause_set;
	logic [CAUSE_W-1:0] cause_clr;

	always_comb begin
		cause_set              = '0;
		cause_set[CAUSE_PIN]   = pin_rst;                         // [RULE5]
		cause_set[CAUSE_WDT]   = wdt_s;                           // [RULE11]
		cause_set[CAUSE_LVR]   = lv_rst;                          // [RULE8]
		cause_set[CAUSE_BOD]   = bod_rst;                         // [RULE2]
		cause_set[CAUSE_MCU]   = mcu_req;                         // [RULE16]
		cause_set[CAUSE_CORE]  = core_req;                        // [RULE14]
		cause_set[CAUSE_LOCK]  = lock_rst;                        // [RULE12]
		cause_set[CAUSE_POR]   = chip_req;                        // [RULE15]
		cause_clr = (apb_wr && paddr == ADDR_CAUSE) ? pwdata[CAUSE_W-1:0] : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause_status <= CAUSE_POR_VAL;                   // [RULE3]
		end else begin
			reset_cause_status <= (reset_cause_status & ~cause_clr) | cause_set; // [RULE21]
		end
	end

	// ------------------------------------------------------------
	// Voltage detect control
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lowvolt_reset_enable     <= 1'b1;                      // [RULE8]
			lowvolt_deglitch_select  <= DG_OFF;
			brownout_deglitch_select <= DG_OFF;
			brownout_enable          <= 1'b0;
			brownout_level           <= 2'h0;
			brownout_reset_enable    <= 1'b0;
			cfg_loaded               <= 1'b0;
		end else if (!cfg_loaded || (full_grp && !bod_rst) || lock_rst || mcu_req) begin
			// Brown-out itself keeps these so the detector stays armed
			brownout_enable       <= user_config_word[CFG_BROWNOUT_ENABLE];          // [RULE10]
			brownout_level        <= user_config_word[CFG_BROWNOUT_LEVEL_LO +: 2];
			brownout_reset_enable <= user_config_word[CFG_BODRST];
			cfg_loaded            <= 1'b1;
		end else if (apb_wr && paddr == ADDR_VDCTL) begin
			brownout_enable          <= pwdata[VD_BROWNOUT_ENABLE];
			brownout_level           <= pwdata[VD_BROWNOUT_LEVEL_LO +: 2];
			brownout_reset_enable    <= pwdata[VD_BODRST];
			lowvolt_reset_enable     <= pwdata[VD_LOWVOLT_RESET_ENABLE];
			brownout_deglitch_select <= pwdata[VD_BODDG_LO +: 3];
			lowvolt_deglitch_select  <= pwdata[VD_LVRDG_LO +: 3];
		end
	end

	// ------------------------------------------------------------
	// Watchdog control, boot select, oscillator flags
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_control <= WDCTL_RST_VAL;
		end else if (full_grp || !cfg_loaded) begin
			watchdog_control <= WDCTL_RST_VAL;                             // [RULE17]
			watchdog_control[CFG_WDT_RST] <= user_config_word[CFG_WDT_RST];
			watchdog_control[CFG_WDT_EN]  <= user_config_word[CFG_WDT_EN];
		end else if (apb_wr && paddr == ADDR_WDCTL) begin
			watchdog_control <= pwdata[15:0];                              // [RULE18]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_select <= 1'b0;
		end else if (!cfg_loaded || (full_grp && !mcu_req)) begin
			boot_select <= user_config_word[CFG_BOOT];                    // [RULE15]
		end else if (apb_wr && paddr == ADDR_BOOT) begin
			boot_select <= pwdata[0];                                      // [RULE16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_stable <= OSCSTB_RST_VAL;                                  // [RULE18]
		end else begin
			osc_stable <= osc_stable | osc_stable_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			software_reset_control <= 2'h0;
		end else begin
			// Self-clearing: the request is a one-cycle pulse
			software_reset_control <= {core_req, chip_req};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			voltage_detect_control_q <= 8'h00;
		end else begin
			voltage_detect_control_q <= {lowvolt_reset_enable, 3'h0, brownout_reset_enable,
				brownout_level, brownout_enable};
		end
	end

	// ------------------------------------------------------------
	// APB slave: one wait-free access phase
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	logic        addr_ok;

	always_comb begin
		rd_mux  = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
			ADDR_CAUSE:  rd_mux = {23'h0, reset_cause_status};
			ADDR_SWRST:  rd_mux = {30'h0, software_reset_control};
			ADDR_VDCTL:  rd_mux = {17'h0, lowvolt_deglitch_select, 1'b0,
				brownout_deglitch_select, lowvolt_reset_enable, 3'h0,
				brownout_reset_enable, brownout_level, brownout_enable};
			ADDR_WDCTL:  rd_mux = {16'h0, watchdog_control};
			ADDR_OSCSTB: rd_mux = {28'h0, osc_stable};
			ADDR_BOOT:   rd_mux = {31'h0, boot_select};
			default:     addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end
endmodule : srctl_top

// ### srctl_top_sva.sv
`timescale 1ns/1ps
module srctl_top_sva
	import srctl_pkg::*;
(
	input wire logic           pclk,                     // clock
	input wire logic           presetn,                  // power-on reset, low
	input wire logic           psel,                     // select
	input wire logic           penable,                  // enable
	input wire logic           pwrite,                   // direction
	input wire logic [11:0]    paddr,                    // address
	input wire logic [31:0]    pwdata,                   // write data
	input wire logic [31:0]    prdata,                   // read data
	input wire logic           pready,                   // ready
	input wire logic           pslverr,                  // error
	input wire logic           external_reset_pin_n,     // reset pin
	input wire logic           system_reset_request_bit, // core request
	input wire srctl_hw_src_t  hw_src,                   // hardware sources
	input wire srctl_rst_out_t rst_out,                  // reset outputs
	input wire logic           boot_select               // boot select
);
	// ------------------------------------------------------------
	// Pin low time, raw, before the synchroniser
	// ------------------------------------------------------------
	logic [15:0] low_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 16'h0000;
		end else if (external_reset_pin_n) begin
			low_cnt <= 16'h0000;
		end else if (low_cnt != 16'hFFFF) begin
			low_cnt <= low_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup_acc;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_swr(v);
		psel && penable && pready && pwrite && paddr == ADDR_SWRST && pwdata[1:0] == v;
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	chk_apb_ready: assert property (s_setup_acc |-> pready)
		else $error("no ready in access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_bad_addr: assert property (pready && paddr > ADDR_BOOT |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_core_spare: assert property (s_swr(2'b10) |=> (!rst_out.periph_rst)[*8])
		else $error("core reset touched peripherals");
	chk_core_hit: assert property (s_swr(2'b10) |-> ##[1:16] rst_out.core_rst)
		else $error("core reset bit ignored");
	chk_chip_hit: assert property (s_swr(2'b01) |-> ##[1:16] (rst_out.periph_rst && rst_out.boot_reload))
		else $error("chip reset bit ignored");
	chk_sysreq_keep: assert property ($rose(system_reset_request_bit) |-> ##[1:16] (rst_out.core_rst && rst_out.periph_rst && !rst_out.boot_reload))
		else $error("system request reset wrong");
	chk_wdt_reset: assert property ($rose(hw_src.wdt_timeout) |-> ##[2:16] (rst_out.core_rst && rst_out.periph_rst))
		else $error("watchdog reset missing");
	chk_lockup_reset: assert property ($rose(hw_src.core_lockup) && !hw_src.debug_mode |-> ##[2:16] rst_out.core_rst)
		else $error("lockup reset missing");
	chk_lockup_debug: assert property ((hw_src.debug_mode && hw_src.core_lockup && !psel)[*4] |=> !rst_out.core_rst)
		else $error("lockup reset during debug");
	chk_pin_filter: assert property ($rose(rst_out.periph_rst) && !external_reset_pin_n |-> low_cnt > PIN_FILTER_CYC)
		else $error("pin reset before filter time");
	chk_pin_hold: assert property (low_cnt > PIN_FILTER_CYC + 8 |-> rst_out.periph_rst)
		else $error("pin low but no reset");
	chk_boot_keep: assert property (rst_out.periph_rst && !rst_out.boot_reload && !$past(rst_out.boot_reload) |-> $stable(boot_select))
		else $error("boot select changed without reload");
endmodule : srctl_top_sva

bind srctl_top srctl_top_sva u_srctl_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .external_reset_pin_n(external_reset_pin_n),
	.system_reset_request_bit(system_reset_request_bit), .hw_src(hw_src),
	.rst_out(rst_out), .boot_select(boot_select));

// ### tb_system_reset_controller.sv
`timescale 1ns/1ps
module tb_system_reset_controller
	import srctl_pkg::*;
;
	localparam logic [31:0] CFG    = 32'h00B0_0082;
	localparam logic [31:0] WD_EXP = {16'h0000, WDCTL_RST_VAL} | (CFG & 32'h0000_0082);
	localparam logic [31:0] VD_EXP = 32'h0000_0080 | {28'h0, CFG[20], CFG[22:21], CFG[23]};
	logic           pclk, presetn, psel, penable, pwrite, cancel, pready, pslverr, re;
	logic           pin_n, sysreq, boot;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata, cfg, rq;
	logic [3:0]     osc_set, lvl;
	logic [2:0]     fire;
	logic [15:0]    wdctl;
	logic [7:0]     vdq;
	srctl_hw_src_t  hw_src;
	srctl_rst_out_t rst_out;
	int             err_count, checked, n;

	srctl_top u_srctl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_reset_pin_n(pin_n), .user_config_word(cfg),
		.system_reset_request_bit(sysreq), .hw_src(hw_src), .osc_stable_set(osc_set),
		.rst_out(rst_out), .watchdog_control(wdctl), .voltage_detect_control_q(vdq),
		.boot_select(boot));
	srctl_partner u_srctl_partner (.pclk(pclk), .presetn(presetn), .rst_out(rst_out),
		.fire(fire), .cancel(cancel), .lvl(lvl), .hw_src(hw_src),
		.external_reset_pin_n(pin_n), .system_reset_request_bit(sysreq));

	always #5 pclk = ~pclk;

	// ------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		chk("pready wait", 32'h1, i);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), exp, rq);
		chk($sformatf("pslverr %h", a), {31'h0, a > ADDR_BOOT}, {31'h0, re});
	endtask : rd

	// Waits up to n cycles; reports whether any reset output rose
	task automatic see(input int n, input logic want);
		int i;
		i = 0;
		do begin
			@(negedge pclk);
			i++;
		end while (i < n && rst_out === 3'h0);
		chk("reset seen", {31'h0, want}, {31'h0, rst_out !== 3'h0});
	endtask : see

	task automatic quiet;
		n = 0;
		while (n < 8000 && rst_out !== 3'h0) begin
			@(negedge pclk);
			n++;
		end
		repeat (3) @(posedge pclk);
	endtask : quiet

	task automatic go(input logic [2:0] f);
		@(posedge pclk);
		fire <= f;
		@(posedge pclk);
		fire <= 3'h0;
	endtask : go

	task automatic set_lvl(input int b, input logic v);
		@(posedge pclk);
		lvl[b] <= v;
	endtask : set_lvl

	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	initial begin
		#400_000;
		err_count++;
		conclude();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, cancel} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cfg = CFG;
		{osc_set, lvl, fire} = 11'h0;
		err_count = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		chk("rst_out in reset", 32'h7, {29'h0, rst_out});
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(ADDR_CAUSE, {23'h0, CAUSE_POR_VAL});
		rd(ADDR_VDCTL, VD_EXP);
		chk("vd out", VD_EXP, {24'h0, vdq});
		rd(ADDR_WDCTL, WD_EXP);
		chk("wd boot out", {15'h0, CFG[CFG_BOOT], WD_EXP[15:0]}, {15'h0, boot, wdctl});
		rd(ADDR_OSCSTB, 32'h0);
		rd(ADDR_BOOT, {31'h0, CFG[CFG_BOOT]});
		rd(12'h018, 32'h0);
		wr(ADDR_CAUSE, 32'h1);
		rd(ADDR_CAUSE, 32'h0);
		@(posedge pclk);
		osc_set <= 4'hF;
		@(posedge pclk);
		osc_set <= 4'h0;
		rd(ADDR_OSCSTB, 32'hF);
		go(3'b001);
		see(40, 1'b1);
		quiet();
		rd(ADDR_CAUSE, 32'h1 << CAUSE_WDT);
		rd(ADDR_OSCSTB, 32'hF);
		rd(ADDR_WDCTL, WD_EXP);
		wr(ADDR_WDCTL, 32'h1234);
		wr(ADDR_BOOT, 32'h0);
		go(3'b100);
		see(40, 1'b1);
		quiet();
		rd(ADDR_CAUSE, (32'h1 << CAUSE_WDT) | (32'h1 << CAUSE_MCU));
		rd(ADDR_BOOT, 32'h0);
		rd(ADDR_WDCTL, 32'h1234);
		wr(ADDR_CAUSE, 32'h1 << CAUSE_WDT);
		rd(ADDR_CAUSE, 32'h1 << CAUSE_MCU);
		wr(ADDR_CAUSE, 32'h1FF);
		wr(ADDR_SWRST, 32'h1 << SW_CHIP);
		see(40, 1'b1);
		quiet();
		rd(ADDR_CAUSE, 32'h1 << CAUSE_POR);
		rd(ADDR_BOOT, {31'h0, CFG[CFG_BOOT]});
		rd(ADDR_WDCTL, WD_EXP);
		wr(ADDR_CAUSE, 32'h1FF);
		wr(ADDR_WDCTL, 32'h1234);
		wr(ADDR_SWRST, 32'h1 << SW_CORE);
		see(40, 1'b1);
		quiet();
		rd(ADDR_CAUSE, 32'h1 << CAUSE_CORE);
		rd(ADDR_WDCTL, 32'h1234);
		chk("vd out", VD_EXP, {24'h0, vdq});
		set_lvl(2, 1'b1);
		repeat (4) @(posedge pclk);
		go(3'b010);
		see(60, 1'b0);
		@(posedge pclk);
		cancel <= 1'b1;
		@(posedge pclk);
		cancel <= 1'b0;
		set_lvl(2, 1'b0);
		repeat (4) @(posedge pclk);
		go(3'b010);
		see(40, 1'b1);
		quiet();
		rd(ADDR_CAUSE, (32'h1 << CAUSE_CORE) | (32'h1 << CAUSE_LOCK));
		wr(ADDR_CAUSE, 32'h1FF);
		set_lvl(3, 1'b1);
		see(3150, 1'b0);
		see(100, 1'b1);
		repeat (300) @(posedge pclk);
		set_lvl(3, 1'b0);
		quiet();
		chk("pin release", 32'h1, {31'h0, n > PIN_FILTER_CYC});
		rd(ADDR_CAUSE, 32'h1 << CAUSE_PIN);
		wr(ADDR_CAUSE, 32'h1FF);
		wr(ADDR_VDCTL, 32'h0000_2209);
		wr(ADDR_VDCTL, 32'h0000_2289);
		set_lvl(0, 1'b1);
		see(1000, 1'b0);
		set_lvl(0, 1'b0);
		repeat (20000) @(posedge pclk);
		set_lvl(0, 1'b1);
		see(50, 1'b0);
		see(100, 1'b1);
		set_lvl(0, 1'b0);
		quiet();
		chk("lvr release", 32'h1, {31'h0, n >= 64});
		rd(ADDR_CAUSE, 32'h1 << CAUSE_LVR);
		wr(ADDR_CAUSE, 32'h1FF);
		wr(ADDR_VDCTL, 32'h0000_0209);
		set_lvl(1, 1'b1);
		see(50, 1'b0);
		see(100, 1'b1);
		set_lvl(1, 1'b0);
		quiet();
		rd(ADDR_CAUSE, 32'h1 << CAUSE_BOD);
		conclude();
	end
endmodule : tb_system_reset_controller
